// *** core/sfm_pkg.sv ***
// Package for the external memory bus mapper: modes, widths, bit positions.
// Assumes one system clock that also clocks the SDRAM.
package sfm_pkg;

    localparam int ADDR_W = 20;
    localparam int DATA_W = 32;
    localparam int FLASH_DATA_W = 16;
    localparam int FLASH_ADDR_W = 20;
    localparam int SD_ADDR_W = 12;
    localparam int BANK_LO = 15;
    localparam int BANK_HI = 16;
    localparam int BE_LO_POS = 18;
    localparam int BE_HI_POS = 19;
    localparam int XLAT_SHIFT = 1;

    localparam logic CFG_LOW_COST = 1'b0;
    localparam logic CFG_HIGH_END = 1'b1;
    localparam logic CFG_ONE_SDRAM = 1'b0;
    localparam logic CFG_TWO_SDRAM = 1'b1;
    localparam logic CLK_RUN_RST = 1'b1;

    typedef struct packed {
        logic high_end;
        logic two_sdram;
        logic sdclk_run;
    } sfm_cfg_s;

    localparam sfm_cfg_s CFG_RST = '{
        high_end: CFG_LOW_COST,
        two_sdram: CFG_ONE_SDRAM,
        sdclk_run: CLK_RUN_RST
    };

    typedef enum logic [2:0] {
        SFM_IDLE = 3'b001,
        SFM_SDRAM = 3'b010,
        SFM_FLASH = 3'b100
    } sfm_state_e;

    typedef struct packed {
        logic valid;
        logic to_flash;
        logic write;
        logic [ADDR_W-1:0] addr;
        logic [3:0] be;
        logic [DATA_W-1:0] wdata;
    } sfm_req_s;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [1:0] byte_lane_mask_n;
        logic [DATA_W-1:0] dq_out;
        logic [1:0] dq_oe;
        logic flash_oe;
        logic sdram_cs;
    } sfm_pins_s;

endpackage

// *** core/sfm_clk_gate.sv ***
// SDRAM clock gate: holds the SDRAM clock off while software stops it.
// Assumes a glitch-free enable is enough; enable is registered and changes on the rising edge of mclk.
`timescale 1ns/1ps
module sfm_clk_gate (
    input wire logic mclk,
    input wire logic rst,
    input wire logic run,
    output logic en_reg
);
    logic en_next;

    always_comb begin
        en_next = run;
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            en_reg <= sfm_pkg::CLK_RUN_RST;
        end else begin
            en_reg <= en_next;
        end
    end
endmodule

// *** core/sfm_mapper.sv ***
// External memory bus mapper: shared address bus to SDRAM and Flash.
// Assumes requests come synchronous to mclk; command timing is outside.
`timescale 1ns/1ps
module sfm_mapper (
    input wire logic mclk,
    input wire logic rst,
    input wire logic cfg_wr,
    input wire sfm_pkg::sfm_cfg_s cfg_in,
    input wire sfm_pkg::sfm_req_s req,
    input wire logic [sfm_pkg::DATA_W-1:0] sdram_dq_in,
    input wire logic [sfm_pkg::FLASH_DATA_W-1:0] flash_dq_in,
    output sfm_pkg::sfm_cfg_s cfg_reg,
    output sfm_pkg::sfm_pins_s pins_reg,
    output logic sdram_clk_en_reg,
    output logic flash_rd_n_reg,
    output logic [sfm_pkg::DATA_W-1:0] rdata_reg,
    output logic rvalid_reg,
    output logic wr_refused_reg
);
    sfm_pkg::sfm_cfg_s cfg_next;
    sfm_pkg::sfm_pins_s pins_next;
    sfm_pkg::sfm_state_e st_reg, st_next;
    logic flash_rd_n_next;
    logic [sfm_pkg::DATA_W-1:0] rdata_next;
    logic rvalid_next;
    logic wr_refused_next;
    logic to_flash_reg, to_flash_next;
    logic wide_reg, wide_next;

    // Translates an internal address for an SDRAM access
    function automatic logic [sfm_pkg::ADDR_W-1:0] xlat(
        input logic [sfm_pkg::ADDR_W-1:0] a,
        input logic high_end,
        input logic [3:0] be
    );
        logic [sfm_pkg::ADDR_W-1:0] r;
        r = a;
        if (high_end) begin
            r[sfm_pkg::SD_ADDR_W-1:0] =
                a[sfm_pkg::SD_ADDR_W-1+sfm_pkg::XLAT_SHIFT:
                  sfm_pkg::XLAT_SHIFT];
            // Active-low lower-lane masks
            r[sfm_pkg::BE_LO_POS] = ~be[0];
            r[sfm_pkg::BE_HI_POS] = ~be[1];
        end
        return r;
    endfunction

    // Configuration setting
    always_comb begin
        cfg_next = cfg_reg;
        if (cfg_wr) begin
            cfg_next = cfg_in;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cfg_reg <= sfm_pkg::CFG_RST;
        end else begin
            cfg_reg <= cfg_next;
        end
    end

    // SDRAM clock always supplied, gated only by software
    sfm_clk_gate sfm_clk_gate_inst (
        .mclk(mclk),
        .rst(rst),
        .run(cfg_reg.sdclk_run),
        .en_reg(sdram_clk_en_reg)
    );

    // Bus steering
    always_comb begin
        pins_next = pins_reg;
        st_next = sfm_pkg::SFM_IDLE;
        flash_rd_n_next = 1'b1;
        rdata_next = rdata_reg;
        rvalid_next = 1'b0;
        wr_refused_next = 1'b0;
        to_flash_next = to_flash_reg;
        wide_next = wide_reg;
        pins_next.dq_oe = 2'b00;
        pins_next.flash_oe = 1'b0;
        pins_next.sdram_cs = 1'b0;
        case (st_reg)
            sfm_pkg::SFM_IDLE,
            sfm_pkg::SFM_SDRAM,
            sfm_pkg::SFM_FLASH: begin
                if (st_reg != sfm_pkg::SFM_IDLE) begin
                    rvalid_next = 1'b1;
                    if (to_flash_reg) begin
                        // Flash data is 16 bits wide
                        rdata_next = {16'h0000, flash_dq_in};
                    end else if (wide_reg) begin
                        rdata_next = sdram_dq_in;
                    end else begin
                        rdata_next = {16'h0000, sdram_dq_in[15:0]};
                    end
                end
                if (req.valid && req.to_flash && req.write) begin
                    wr_refused_next = 1'b1;
                end else if (req.valid && req.to_flash) begin
                    st_next = sfm_pkg::SFM_FLASH;
                    to_flash_next = 1'b1;
                    // Untranslated, 20 lines
                    pins_next.addr = req.addr;
                    pins_next.flash_oe = 1'b1;
                    flash_rd_n_next = 1'b0;
                end else if (req.valid) begin
                    to_flash_next = 1'b0;
                    pins_next.sdram_cs = 1'b1;
                    pins_next.addr = xlat(req.addr, cfg_reg.high_end,
                        req.be);
                    wide_next = cfg_reg.high_end;
                    pins_next.byte_lane_mask_n = cfg_reg.high_end ?
                        ~req.be[3:2] : ~req.be[1:0];
                    pins_next.dq_out = req.wdata;
                    if (req.write) begin
                        // Upper half only in 32-bit mode
                        pins_next.dq_oe = {cfg_reg.high_end, 1'b1};
                    end else begin
                        st_next = sfm_pkg::SFM_SDRAM;
                    end
                end
            end
            default: begin
                st_next = sfm_pkg::SFM_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            st_reg <= sfm_pkg::SFM_IDLE;
            pins_reg <= '0;
            flash_rd_n_reg <= 1'b1;
            rdata_reg <= 32'h00000000;
            rvalid_reg <= 1'b0;
            wr_refused_reg <= 1'b0;
            to_flash_reg <= 1'b0;
            wide_reg <= 1'b0;
        end else begin
            st_reg <= st_next;
            pins_reg <= pins_next;
            flash_rd_n_reg <= flash_rd_n_next;
            rdata_reg <= rdata_next;
            rvalid_reg <= rvalid_next;
            wr_refused_reg <= wr_refused_next;
            to_flash_reg <= to_flash_next;
            wide_reg <= wide_next;
        end
    end

    a_flash_no_write: assert property (
        @(posedge mclk) disable iff (rst)
        (req.valid && req.to_flash && req.write) |=>
        (wr_refused_reg && flash_rd_n_reg && pins_reg.dq_oe == 2'b00))
        else $error("Flash write not refused");

    a_flash_untrans: assert property (
        @(posedge mclk) disable iff (rst)
        (req.valid && req.to_flash && !req.write) |=>
        (pins_reg.addr == $past(req.addr) && !flash_rd_n_reg))
        else $error("Flash address altered");

    a_xlat_high: assert property (
        @(posedge mclk) disable iff (rst)
        (req.valid && !req.to_flash && cfg_reg.high_end) |=>
        (pins_reg.addr[11:0] == $past(req.addr[12:1])))
        else $error("High-end translation wrong");

    a_low_passthru: assert property (
        @(posedge mclk) disable iff (rst)
        (req.valid && !req.to_flash && !cfg_reg.high_end) |=>
        (pins_reg.addr == $past(req.addr)))
        else $error("Low-cost address altered");

    a_bank_kept: assert property (
        @(posedge mclk) disable iff (rst)
        (req.valid && !req.to_flash) |=>
        (pins_reg.addr[16:15] == $past(req.addr[16:15])))
        else $error("Bank select moved");

    a_be_lanes: assert property (
        @(posedge mclk) disable iff (rst)
        (req.valid && !req.to_flash && cfg_reg.high_end) |=>
        (pins_reg.addr[19:18] == ~$past(req.be[1:0]) &&
         pins_reg.byte_lane_mask_n == ~$past(req.be[3:2])))
        else $error("Byte enable lanes wrong");

    a_upper_half: assert property (
        @(posedge mclk) disable iff (rst)
        (req.valid && !req.to_flash && req.write && !cfg_reg.high_end) |=>
        (pins_reg.dq_oe == 2'b01))
        else $error("Upper half driven in low-cost");

    a_cfg_load: assert property (
        @(posedge mclk) disable iff (rst)
        cfg_wr |=>
        (cfg_reg == $past(cfg_in)))
        else $error("Config not taken");

    a_clk_follow: assert property (
        @(posedge mclk) disable iff (rst)
        $changed(cfg_reg.sdclk_run) |=>
        (sdram_clk_en_reg == $past(cfg_reg.sdclk_run)))
        else $error("SDRAM clock gate late");

    a_rd_return: assert property (
        @(posedge mclk) disable iff (rst)
        (req.valid && !req.write) |=>
        ##1 rvalid_reg)
        else $error("Read data not returned");

    a_flash_strobe: assert property (
        @(posedge mclk) disable iff (rst)
        !flash_rd_n_reg |->
        (pins_reg.flash_oe && !pins_reg.sdram_cs))
        else $error("Flash strobe outside a Flash read");

    a_one_target: assert property (
        @(posedge mclk) disable iff (rst)
        pins_reg.flash_oe |->
        !pins_reg.sdram_cs)
        else $error("SDRAM and Flash selected together");

    a_clk_running: assert property (
        @(posedge mclk) disable iff (rst)
        (cfg_reg.sdclk_run && $past(cfg_reg.sdclk_run)) |->
        sdram_clk_en_reg)
        else $error("SDRAM clock stopped while enabled");

    a_flash_rdata: assert property (
        @(posedge mclk) disable iff (rst)
        (req.valid && req.to_flash && !req.write) |=>
        ##1 (rdata_reg == {16'h0000, $past(flash_dq_in)}))
        else $error("Flash read data wrong");

    a_narrow_rdata: assert property (
        @(posedge mclk) disable iff (rst)
        (req.valid && !req.to_flash && !req.write && !cfg_reg.high_end) |=>
        ##1 (rdata_reg == {16'h0000, $past(sdram_dq_in[15:0])}))
        else $error("16-bit read data wrong");

    a_wide_rdata: assert property (
        @(posedge mclk) disable iff (rst)
        (req.valid && !req.to_flash && !req.write && cfg_reg.high_end) |=>
        ##1 (rdata_reg == $past(sdram_dq_in)))
        else $error("32-bit read data wrong");

    a_both_halves: assert property (
        @(posedge mclk) disable iff (rst)
        (req.valid && !req.to_flash && req.write && cfg_reg.high_end) |=>
        (pins_reg.dq_oe == 2'b11 && pins_reg.dq_out == $past(req.wdata)))
        else $error("32-bit write not on both halves");

    a_flash_no_oe: assert property (
        @(posedge mclk) disable iff (rst)
        (req.valid && req.to_flash) |=>
        (pins_reg.dq_oe == 2'b00 && !pins_reg.sdram_cs))
        else $error("Data bus driven during Flash access");

    a_sd_read_cs: assert property (
        @(posedge mclk) disable iff (rst)
        (req.valid && !req.to_flash && !req.write) |=>
        (pins_reg.sdram_cs && pins_reg.dq_oe == 2'b00 && flash_rd_n_reg))
        else $error("SDRAM read select wrong");

    a_cfg_hold: assert property (
        @(posedge mclk) disable iff (rst)
        !cfg_wr |=>
        (cfg_reg == $past(cfg_reg)))
        else $error("Config changed without a load");

    a_idle_quiet: assert property (
        @(posedge mclk) disable iff (rst)
        !req.valid |=>
        (flash_rd_n_reg && !pins_reg.sdram_cs && !pins_reg.flash_oe))
        else $error("Strobe active without a request");

    a_upper_kept: assert property (
        @(posedge mclk) disable iff (rst)
        (req.valid && !req.to_flash && cfg_reg.high_end) |=>
        (pins_reg.addr[17:12] == $past(req.addr[17:12])))
        else $error("Translation touched upper address bits");

    a_refuse_only: assert property (
        @(posedge mclk) disable iff (rst)
        wr_refused_reg |->
        $past(req.valid && req.to_flash && req.write))
        else $error("Refusal without a Flash write");
endmodule

// *** test/sfm_mem_model.sv ***
// Model of the SDRAM and Flash that answer on the shared bus.
// Assumes the mapper's pins are registered on mclk.
`timescale 1ns/1ps
module sfm_mem_model (
    input wire logic mclk,
    input wire logic rst,
    input wire sfm_pkg::sfm_pins_s pins,
    input wire logic flash_rd_n,
    output logic [sfm_pkg::DATA_W-1:0] sdram_dq,
    output logic [sfm_pkg::FLASH_DATA_W-1:0] flash_dq
);
    logic [15:0] idle_reg;
    // Released bus shows a pattern that moves every cycle
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            idle_reg <= 16'h0000;
        end else begin
            idle_reg <= idle_reg + 16'h1357;
        end
    end
    // SDRAM drives only while selected
    assign sdram_dq = pins.sdram_cs ? {pins.addr[15:0], ~pins.addr[15:0]}
                                    : {idle_reg, ~idle_reg};
    // Flash answers strobes only, no clock
    assign flash_dq = (pins.flash_oe && !flash_rd_n) ?
                      (pins.addr[15:0] ^ 16'hC3C3) : ~idle_reg;
endmodule

// *** test/sfm_mapper_test.sv ***
// Testbench for the memory bus mapper with its memory model.
// Assumes nothing beyond the design files and the model.
`timescale 1ns/1ps
module sfm_mapper_test;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic cfg_wr = 1'b0;
    sfm_pkg::sfm_cfg_s cfg_in = sfm_pkg::CFG_RST;
    sfm_pkg::sfm_req_s req = '0;
    logic [31:0] sdram_dq_in;
    logic [15:0] flash_dq_in;
    sfm_pkg::sfm_cfg_s cfg_reg;
    sfm_pkg::sfm_pins_s pins_reg;
    logic sdram_clk_en_reg, flash_rd_n_reg, rvalid_reg, wr_refused_reg;
    logic [31:0] rdata_reg;
    int mismatches = 0;
    int comparisons = 0;
    localparam logic [31:0] WD = 32'hA5C3_0F96;

    always #2.5 mclk = ~mclk;

    sfm_mapper sfm_mapper_inst (.mclk(mclk), .rst(rst), .cfg_wr(cfg_wr),
        .cfg_in(cfg_in), .req(req), .sdram_dq_in(sdram_dq_in),
        .flash_dq_in(flash_dq_in), .cfg_reg(cfg_reg), .pins_reg(pins_reg),
        .sdram_clk_en_reg(sdram_clk_en_reg),
        .flash_rd_n_reg(flash_rd_n_reg), .rdata_reg(rdata_reg),
        .rvalid_reg(rvalid_reg), .wr_refused_reg(wr_refused_reg));
    sfm_mem_model sfm_mem_model_inst (.mclk(mclk), .rst(rst),
        .pins(pins_reg), .flash_rd_n(flash_rd_n_reg),
        .sdram_dq(sdram_dq_in), .flash_dq(flash_dq_in));

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic summarize;
        $display("Comparisons %0d, mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // One request; returns at the negedge where its pins are visible
    task automatic send(input logic fl, input logic wr,
                        input logic [19:0] a, input logic [3:0] be);
        @(negedge mclk);
        req = '{valid: 1'b1, to_flash: fl, write: wr, addr: a, be: be,
                wdata: WD};
        @(negedge mclk);
        req.valid = 1'b0;
    endtask

    task automatic set_cfg(input logic he, input logic two, input logic run);
        @(negedge mclk);
        cfg_in = '{high_end: he, two_sdram: two, sdclk_run: run};
        cfg_wr = 1'b1;
        @(negedge mclk);
        cfg_wr = 1'b0;
        check(32'(cfg_reg), 32'({he, two, run}));
    endtask

    task automatic t_reset;
        check(32'(cfg_reg), 32'(sfm_pkg::CFG_RST));
        check(32'({sdram_clk_en_reg, flash_rd_n_reg}), 32'h3);
    endtask

    task automatic t_low_cost;
        send(1'b0, 1'b0, 20'h9ABCD, 4'h6);
        check(32'(pins_reg.addr), 32'h9ABCD);
        check(32'(pins_reg.byte_lane_mask_n), 32'h1);
        @(negedge mclk);
        check(32'(rvalid_reg), 32'h1);
        check(rdata_reg, {16'h0000, 16'h5432});
        send(1'b0, 1'b1, 20'h01234, 4'h3);
        check(32'(pins_reg.dq_oe), 32'h1);
    endtask

    task automatic t_high_end;
        logic [19:0] a;
        logic [19:0] x;
        a = 20'h6ABCD;
        x = {2'b10, a[17:12], a[12:1]};
        set_cfg(1'b1, 1'b1, 1'b1);
        send(1'b0, 1'b1, a, 4'b1001);
        check(32'(pins_reg.addr), 32'(x));
        check(32'(pins_reg.byte_lane_mask_n), 32'h1);
        check(32'({pins_reg.dq_oe, pins_reg.sdram_cs}), 32'h7);
        check(pins_reg.dq_out, WD);
        send(1'b0, 1'b0, a, 4'b1001);
        @(negedge mclk);
        check(rdata_reg, {x[15:0], ~x[15:0]});
    endtask

    task automatic t_flash;
        send(1'b1, 1'b0, 20'hFEDCB, 4'hF);
        check(32'(pins_reg.addr), 32'hFEDCB);
        check(32'({pins_reg.flash_oe, flash_rd_n_reg}), 32'h2);
        check(32'(pins_reg.sdram_cs), 32'h0);
        @(negedge mclk);
        check(rdata_reg, {16'h0000, 16'hEDCB ^ 16'hC3C3});
        send(1'b1, 1'b1, 20'h00010, 4'hF);
        check(32'(wr_refused_reg), 32'h1);
        check(32'({pins_reg.dq_oe, pins_reg.flash_oe}), 32'h0);
    endtask

    task automatic t_clock;
        set_cfg(1'b1, 1'b1, 1'b0);
        @(negedge mclk);
        check(32'(sdram_clk_en_reg), 32'h0);
        set_cfg(1'b1, 1'b1, 1'b1);
        @(negedge mclk);
        check(32'(sdram_clk_en_reg), 32'h1);
    endtask

    initial begin
        repeat (10) @(posedge mclk);
        @(negedge mclk);
        rst = 1'b0;
        t_reset();
        t_low_cost();
        t_high_end();
        t_flash();
        t_clock();
        summarize();
    end

    initial begin
        #(5 * 2000);
        mismatches++;
        summarize();
    end
endmodule
